// ---- ipas_top.sv ----
/*
  Interrupt priority and status block: per-source priority registers,
  request flags, enables, CPU level with a return stack, timed disable,
  trap handling, arbitration and the level/vector status register.
  Assumes an AXI4-Lite master with one write and one read in flight,
  peripheral and trap request pulses synchronous to clk_i, and a CPU
  that signals taking and returning from an interrupt.
*/
`timescale 1ns/100ps
module ipas_top
  import ipas_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [7:0]  src_req_i,
  input  wire logic [7:0]  trap_req_i,
  input  wire logic        cpu_ack_i,
  input  wire logic        cpu_return_i,
  output logic             irq_valid_o,
  output logic [3:0]       irq_level_o,
  output logic [6:0]       irq_vector_index_o,
  output logic [3:0]       cpu_level_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte-lane merge of a 16-bit register, keeping only implemented bits
  function automatic logic [15:0] merge16(input logic [15:0] cur, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [15:0] impl);
    logic [15:0] m;
    m = cur;
    if (strb[0]) begin
      m[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      m[15:8] = wd[15:8];
    end
    return m & impl;
  endfunction : merge16

  // Priority as a four-bit level
  function automatic logic [3:0] lvl(input ipas_prio_t p);
    return {1'b0, p};
  endfunction : lvl

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ipas_prio_t   prio [NUM_SRC];
  logic [7:0]   req_flag;
  logic [7:0]   enable;
  logic [7:0]   trap_flag;
  logic         nesting_disable;
  logic [3:0]   cpu_level;
  logic [15:0]  timed_irq_disable;
  logic [3:0]   level_stack [STACK_DEPTH];
  logic [4:0]   stack_ptr;
  ipas_status_t level_vector_status;

  localparam logic [15:0] IMPL_CN_I2C  = 16'h7077;
  localparam logic [15:0] IMPL_CAP_EXT = 16'h7707;
  localparam logic [15:0] IMPL_MID     = 16'h0070;

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  wire logic [15:0] view_cn_i2c  = {1'b0, prio[SRC_CHANGE_NOTIFY], 5'h00,
                                    prio[SRC_I2C_MASTER], 1'b0, prio[SRC_I2C_SLAVE]};
  wire logic [15:0] view_cap_ext = {1'b0, prio[SRC_CAPTURE8], 1'b0, prio[SRC_CAPTURE7],
                                    5'h00, prio[SRC_EXT_IRQ1]};
  wire logic [15:0] view_ext2    = {9'h000, prio[SRC_EXT_IRQ2], 4'h0};
  wire logic [15:0] view_serr    = {9'h000, prio[SRC_SERIAL_ERROR], 4'h0};
  wire logic [15:0] view_ctrl    = {nesting_disable, 11'h000, cpu_level};
  wire logic [15:0] next_cn_i2c  = merge16(view_cn_i2c, s_axi_wdata_i, s_axi_wstrb_i, IMPL_CN_I2C);
  wire logic [15:0] next_cap_ext = merge16(view_cap_ext, s_axi_wdata_i, s_axi_wstrb_i,
                                           IMPL_CAP_EXT);
  wire logic [15:0] next_ext2    = merge16(view_ext2, s_axi_wdata_i, s_axi_wstrb_i, IMPL_MID);
  wire logic [15:0] next_serr    = merge16(view_serr, s_axi_wdata_i, s_axi_wstrb_i, IMPL_MID);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire logic        wr_go  = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o &&
                             !s_axi_bvalid_o;
  wire logic        rd_go  = s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
  wire logic [7:0]  wa     = s_axi_awaddr_i & 8'hFC;
  wire logic [7:0]  ra     = s_axi_araddr_i & 8'hFC;
  wire logic        wr_p0  = wr_go && (wa == OFS_PRIORITY_CN_I2C);
  wire logic        wr_p1  = wr_go && (wa == OFS_PRIORITY_CAPTURE_EXT1);
  wire logic        wr_p2  = wr_go && (wa == OFS_PRIORITY_EXT2);
  wire logic        wr_p3  = wr_go && (wa == OFS_PRIORITY_SERIAL_ERROR);
  wire logic        wr_flg = wr_go && (wa == OFS_REQUEST_FLAGS) && s_axi_wstrb_i[0];
  wire logic        wr_en  = wr_go && (wa == OFS_ENABLES) && s_axi_wstrb_i[0];
  wire logic        wr_ctl = wr_go && (wa == OFS_INTERRUPT_CONTROL);
  wire logic        wr_trp = wr_go && (wa == OFS_TRAP_FLAGS) && s_axi_wstrb_i[0];
  wire logic        wr_tmd = wr_go && (wa == OFS_TIMED_DISABLE);
  wire logic        wr_hit = (wa <= OFS_TIMED_DISABLE);
  logic [15:0]      rd_word;
  logic             rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    if (ra == OFS_PRIORITY_CN_I2C) begin
      rd_word = view_cn_i2c;
    end else if (ra == OFS_PRIORITY_CAPTURE_EXT1) begin
      rd_word = view_cap_ext;
    end else if (ra == OFS_PRIORITY_EXT2) begin
      rd_word = view_ext2;
    end else if (ra == OFS_PRIORITY_SERIAL_ERROR) begin
      rd_word = view_serr;
    end else if (ra == OFS_LEVEL_VECTOR_STATUS) begin
      rd_word = level_vector_status;
    end else if (ra == OFS_REQUEST_FLAGS) begin
      rd_word = {8'h00, req_flag};
    end else if (ra == OFS_ENABLES) begin
      rd_word = {8'h00, enable};
    end else if (ra == OFS_INTERRUPT_CONTROL) begin
      rd_word = view_ctrl;
    end else if (ra == OFS_TRAP_FLAGS) begin
      rd_word = {8'h00, trap_flag};
    end else if (ra == OFS_TIMED_DISABLE) begin
      rd_word = timed_irq_disable;
    end else begin
      rd_word = WORD_ZERO;
      rd_hit  = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  wire logic       timed_irq_disable_on = (timed_irq_disable != WORD_ZERO);
  logic [7:0]      elig;
  ipas_req_t       best;
  ipas_req_t       next_req;

  always_comb begin
    best = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      elig[i] = req_flag[i] && enable[i]
             && (prio[i] != PRIO_OFF)
             && (lvl(prio[i]) > cpu_level)
             && !(timed_irq_disable_on && (lvl(prio[i]) < LEVEL_TOP_USER));
      if (elig[i] && (lvl(prio[i]) >= best.level)) begin
        best.valid        = 1'b1;
        best.level        = lvl(prio[i]);
        best.vector_index = USER_VEC_BASE + 7'(i);
      end
    end
    next_req = best;
    for (int t = 0; t < NUM_TRAP; t++) begin
      if (trap_flag[t]) begin
        next_req.valid        = 1'b1;
        next_req.level        = LEVEL_TRAP_BASE + 4'(t);
        next_req.vector_index = 7'(t);
      end
    end
  end

  // Level taken on acceptance: nesting disabled pins the CPU at the top user level on a user request
  wire logic [3:0] take_level = (nesting_disable && (irq_level_o <= LEVEL_TOP_USER))
                                ? LEVEL_TOP_USER : irq_level_o;
  wire logic       do_push    = cpu_ack_i && irq_valid_o && (stack_ptr != 5'(STACK_DEPTH));
  wire logic       do_pop     = cpu_return_i && !do_push && (stack_ptr != 5'h00);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio[i] <= PRIO_RESET;
      end
    end else begin
      if (wr_p0) begin
        {prio[SRC_CHANGE_NOTIFY], prio[SRC_I2C_MASTER], prio[SRC_I2C_SLAVE]} <=
          {next_cn_i2c[FLD_HI+:3], next_cn_i2c[FLD_LO4+:3], next_cn_i2c[FLD_LO0+:3]};
      end
      if (wr_p1) begin
        {prio[SRC_CAPTURE8], prio[SRC_CAPTURE7], prio[SRC_EXT_IRQ1]} <=
          {next_cap_ext[FLD_HI+:3], next_cap_ext[FLD_MID+:3], next_cap_ext[FLD_LO0+:3]};
      end
      if (wr_p2) begin
        prio[SRC_EXT_IRQ2] <= next_ext2[FLD_LO4+:3];
      end
      if (wr_p3) begin
        prio[SRC_SERIAL_ERROR] <= next_serr[FLD_LO4+:3];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Flags, enables, control and timed disable
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_flag          <= 8'h00;
      enable            <= 8'h00;
      trap_flag         <= 8'h00;
      nesting_disable   <= 1'b0;
      timed_irq_disable <= 16'h0000;
    end else begin
      // Set wins over a write-one-to-clear in the same cycle
      req_flag  <= (req_flag & ~(wr_flg ? s_axi_wdata_i[7:0] : 8'h00)) | src_req_i;
      trap_flag <= (trap_flag & ~(wr_trp ? s_axi_wdata_i[7:0] : 8'h00)) | trap_req_i;
      if (wr_en) begin
        enable <= s_axi_wdata_i[7:0];
      end
      if (wr_ctl && s_axi_wstrb_i[1]) begin
        nesting_disable <= s_axi_wdata_i[CTRL_NEST_DIS];
      end
      if (wr_tmd) begin
        timed_irq_disable <= merge16(timed_irq_disable, s_axi_wdata_i, s_axi_wstrb_i, 16'hFFFF);
      end else if (timed_irq_disable_on) begin
        timed_irq_disable <= timed_irq_disable - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // CPU level and return stack
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_level <= LEVEL_ZERO;
      stack_ptr <= 5'h00;
    end else if (do_push) begin
      cpu_level <= take_level;
      stack_ptr <= stack_ptr + 5'h01;
    end else if (do_pop) begin
      cpu_level <= level_stack[4'(stack_ptr - 5'h01)];
      stack_ptr <= stack_ptr - 5'h01;
    end else if (wr_ctl && s_axi_wstrb_i[0]) begin
      cpu_level <= s_axi_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      level_stack[4'(stack_ptr)] <= cpu_level;
    end
  end

  // ----------------------------------------------------------------------
  // Presented request and status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_valid_o         <= 1'b0;
      irq_level_o         <= LEVEL_ZERO;
      irq_vector_index_o  <= 7'h00;
      level_vector_status <= '0;
      cpu_level_o         <= LEVEL_ZERO;
    end else begin
      irq_valid_o         <= next_req.valid;
      irq_level_o         <= next_req.level;
      irq_vector_index_o  <= next_req.vector_index;
      level_vector_status <= '{pad_hi: 4'h0, new_cpu_level: next_req.level, pad_mid: 1'b0,
                               pending_vector_index: next_req.vector_index};
      cpu_level_o         <= cpu_level;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= RESP_OKAY;
      s_axi_rdata_o   <= 32'h0000_0000;
    end else begin
      s_axi_awready_o <= wr_go;
      s_axi_wready_o  <= wr_go;
      if (wr_go) begin
        s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_awready_o) begin
        s_axi_bvalid_o <= 1'b1;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      s_axi_arready_o <= rd_go;
      if (rd_go) begin
        s_axi_rdata_o <= {16'h0000, rd_word};
        s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule : ipas_top

// ---- ipas_pkg.sv ----
/*
  Package of the interrupt priority and status block: register offsets,
  field positions, reset values and shared types.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package ipas_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PRIORITY_CN_I2C       = 8'h00;
  localparam logic [7:0] OFS_PRIORITY_CAPTURE_EXT1 = 8'h04;
  localparam logic [7:0] OFS_PRIORITY_EXT2         = 8'h08;
  localparam logic [7:0] OFS_PRIORITY_SERIAL_ERROR = 8'h0C;
  localparam logic [7:0] OFS_LEVEL_VECTOR_STATUS   = 8'h10;
  localparam logic [7:0] OFS_REQUEST_FLAGS         = 8'h14;
  localparam logic [7:0] OFS_ENABLES               = 8'h18;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL     = 8'h1C;
  localparam logic [7:0] OFS_TRAP_FLAGS            = 8'h20;
  localparam logic [7:0] OFS_TIMED_DISABLE         = 8'h24;

  // ----------------------------------------------------------------------
  // Sources, levels and fields
  // ----------------------------------------------------------------------
  localparam int NUM_SRC  = 8;
  localparam int NUM_TRAP = 8;
  localparam int STACK_DEPTH = 16;

  // Source index, also the arbitration order on equal level
  localparam int SRC_I2C_SLAVE    = 0;
  localparam int SRC_SERIAL_ERROR = 1;
  localparam int SRC_I2C_MASTER   = 2;
  localparam int SRC_CHANGE_NOTIFY = 3;
  localparam int SRC_EXT_IRQ1     = 4;
  localparam int SRC_CAPTURE7     = 5;
  localparam int SRC_CAPTURE8     = 6;
  localparam int SRC_EXT_IRQ2     = 7;

  localparam int FLD_HI  = 12;
  localparam int FLD_MID = 8;
  localparam int FLD_LO4 = 4;
  localparam int FLD_LO0 = 0;

  localparam logic [2:0]  PRIO_RESET    = 3'h4;
  localparam logic [2:0]  PRIO_OFF      = 3'h0;
  localparam logic [3:0]  LEVEL_TOP_USER = 4'h7;
  localparam logic [3:0]  LEVEL_TRAP_BASE = 4'h8;
  localparam logic [3:0]  LEVEL_ZERO    = 4'h0;
  localparam logic [6:0]  USER_VEC_BASE = 7'h0A;
  localparam int          CTRL_NEST_DIS = 15;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [2:0] ipas_prio_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] level;
    logic [6:0] vector_index;
  } ipas_req_t;

  typedef struct packed {
    logic [3:0] pad_hi;
    logic [3:0] new_cpu_level;
    logic       pad_mid;
    logic [6:0] pending_vector_index;
  } ipas_status_t;

endpackage : ipas_pkg

// ---- ipas_top_sva.sv ----
/*
  Checker of ipas_top port behaviour: presented requests, CPU level moves
  and register bus answers. Assumes nesting disable stays clear.
*/
`timescale 1ns/100ps
module ipas_top_sva
  import ipas_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic [7:0]  trap_req_i,
  input wire logic        cpu_ack_i,
  input wire logic        cpu_return_i,
  input wire logic        irq_valid_o,
  input wire logic [3:0]  irq_level_o,
  input wire logic [6:0]  irq_vector_index_o,
  input wire logic [3:0]  cpu_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence taken_s;
    cpu_ack_i && irq_valid_o;
  endsequence
  sequence back_s;
    taken_s ##1 (cpu_return_i && !cpu_ack_i);
  endsequence

  zero_prio_a: assert property (irq_valid_o |-> irq_level_o != LEVEL_ZERO)
    else $error("request presented at level zero");
  idle_zero_a: assert property (!irq_valid_o |-> irq_level_o == 4'h0 &&
    irq_vector_index_o == 7'h00)
    else $error("idle request fields not zero");
  user_vec_a: assert property (irq_valid_o && irq_level_o < LEVEL_TRAP_BASE |->
    irq_vector_index_o >= USER_VEC_BASE && irq_vector_index_o <= USER_VEC_BASE + 7'h07)
    else $error("user vector index out of range");
  trap_vec_a: assert property (irq_valid_o && irq_level_o >= LEVEL_TRAP_BASE |->
    irq_vector_index_o == {3'h0, irq_level_o - LEVEL_TRAP_BASE})
    else $error("trap vector index does not match level");
  top_trap_a: assert property (trap_req_i[7] |-> ##2 irq_valid_o &&
    irq_level_o == 4'hF)
    else $error("top trap not presented");
  above_cpu_a: assert property (irq_valid_o && irq_level_o < LEVEL_TRAP_BASE &&
    $stable(cpu_level_o) |-> irq_level_o > cpu_level_o)
    else $error("user request not above CPU level");
  ack_level_a: assert property (taken_s |-> ##2 cpu_level_o == $past(irq_level_o, 2))
    else $error("CPU level not raised to taken level");
  ret_level_a: assert property (back_s |-> ##2 cpu_level_o == $past(cpu_level_o, 2))
    else $error("return did not restore CPU level");
  rd_unmap_a: assert property (s_axi_arready_o && s_axi_araddr_i[7:2] > 6'h09 |->
    s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read answered wrongly");
  wr_unmap_a: assert property (s_axi_awready_o && s_axi_awaddr_i[7:2] > 6'h09 |->
    s_axi_bresp_o == RESP_SLVERR)
    else $error("unmapped write answered wrongly");
  upper_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0)
    else $error("read data upper half not zero");
endmodule : ipas_top_sva

bind ipas_top ipas_top_sva u_ipas_top_sva (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .trap_req_i(trap_req_i), .cpu_ack_i(cpu_ack_i),
  .cpu_return_i(cpu_return_i), .irq_valid_o(irq_valid_o), .irq_level_o(irq_level_o),
  .irq_vector_index_o(irq_vector_index_o), .cpu_level_o(cpu_level_o)
);

// ---- ipas_cpu_model.sv ----
/*
  CPU core model facing ipas_top: takes a presented request, serves it for
  svc_cycles_i + 1 cycles, then returns. Takes only while run_i is high; a taken request still returns.
*/
`timescale 1ns/100ps
module ipas_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [7:0] svc_cycles_i,
  input  wire logic       irq_valid_i,
  output logic            cpu_ack_o,
  output logic            cpu_return_o
);
  logic [7:0] remain;
  logic       busy;

  // One-cycle pulses; a new take waits until the return pulse has gone
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_ack_o    <= 1'b0;
      cpu_return_o <= 1'b0;
      busy         <= 1'b0;
      remain       <= 8'h00;
    end else begin
      cpu_ack_o    <= 1'b0;
      cpu_return_o <= 1'b0;
      if (busy) begin
        remain <= remain - 8'h01;
        if (remain == 8'h00) begin
          busy         <= 1'b0;
          cpu_return_o <= 1'b1;
        end
      end else if (run_i && irq_valid_i && !cpu_ack_o && !cpu_return_o) begin
        cpu_ack_o <= 1'b1;
        busy      <= 1'b1;
        remain    <= svc_cycles_i;
      end
    end
  end
endmodule : ipas_cpu_model

// ---- ipas_top_test.sv ----
/*
  Self-checking bench of ipas_top: registers over AXI4-Lite, arbitration,
  masking, timed disable and CPU take/return through ipas_cpu_model.
*/
`timescale 1ns/100ps
module ipas_top_test
  import ipas_pkg::*;
;
  logic        clk_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready, run;
  logic        awready, wready, bvalid, arready, rvalid, ack, ret, irq_valid;
  logic [7:0]  awaddr, araddr, src_req, trap_req, svc;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, irq_level, cpu_level;
  logic [1:0]  bresp, rresp;
  logic [6:0]  irq_vec;
  int          mismatches, compares, acks;

  ipas_top u_ipas_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .src_req_i(src_req), .trap_req_i(trap_req), .cpu_ack_i(ack), .cpu_return_i(ret),
    .irq_valid_o(irq_valid), .irq_level_o(irq_level), .irq_vector_index_o(irq_vec),
    .cpu_level_o(cpu_level)
  );
  ipas_cpu_model u_ipas_cpu_model (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .run_i(run), .svc_cycles_i(svc),
    .irq_valid_i(irq_valid), .cpu_ack_o(ack), .cpu_return_o(ret)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (ack) acks++;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic irq_is(input logic v, input logic [3:0] l, input logic [6:0] x);
    check("irq", {20'h0, irq_valid, irq_level, irq_vec}, {20'h0, v, l, x});
  endtask : irq_is

  // Valids drop on their own ready; one idle edge follows each transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    check("rdata", rdata, ed);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk_i);
  endtask : rd

  task automatic pulse(input logic [7:0] s, input logic [7:0] t);
    src_req <= s;
    trap_req <= t;
    @(posedge clk_i);
    src_req <= 8'h00;
    trap_req <= 8'h00;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  task automatic t_regs();
    logic [15:0] rv [4] = '{16'h4044, 16'h4404, 16'h0040, 16'h0040};
    logic [15:0] mk [4] = '{16'h7077, 16'h7707, 16'h0070, 16'h0070};
    wr(OFS_INTERRUPT_CONTROL, 32'h8000, RESP_OKAY);
    rd(OFS_INTERRUPT_CONTROL, 32'h8000, RESP_OKAY);
    wr(OFS_INTERRUPT_CONTROL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), {16'h0, rv[i]}, RESP_OKAY);
      wr(8'(i * 4), 32'hFFFFFFFF, RESP_OKAY);
      rd(8'(i * 4), {16'h0, mk[i]}, RESP_OKAY);
    end
    wr(OFS_LEVEL_VECTOR_STATUS, 32'hFFFF, RESP_OKAY);
    rd(OFS_LEVEL_VECTOR_STATUS, 32'h0, RESP_OKAY);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
  endtask : t_regs

  task automatic t_levels();
    logic [3:0] lv;
    logic [6:0] x;
    for (int p = 0; p < 8; p++) begin
      lv = 4'(p);
      x = (p != 0) ? 7'h0B : 7'h00;
      wr(OFS_PRIORITY_SERIAL_ERROR, {25'h0, lv[2:0], 4'h0}, RESP_OKAY);
      wr(OFS_REQUEST_FLAGS, 32'h2, RESP_OKAY);
      wr(OFS_ENABLES, 32'h2, RESP_OKAY);
      pulse(8'h02, 8'h00);
      irq_is(p != 0, lv, x);
      rd(OFS_LEVEL_VECTOR_STATUS, {20'h0, lv, 1'b0, x}, RESP_OKAY);
    end
    wr(OFS_ENABLES, 32'h0, RESP_OKAY);
    wr(OFS_REQUEST_FLAGS, 32'h2, RESP_OKAY);
    pulse(8'h02, 8'h00);
    irq_is(1'b0, 4'h0, 7'h00);
    wr(OFS_REQUEST_FLAGS, 32'h2, RESP_OKAY);
  endtask : t_levels

  task automatic t_arb();
    logic [7:0]  ro [8] = '{8'h00, 8'h0C, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h08};
    int          sh [8] = '{0, 4, 4, 12, 0, 8, 12, 4};
    logic [15:0] bs [4] = '{16'h1011, 16'h1101, 16'h0010, 16'h0010};
    for (int i = 0; i < 4; i++) wr(8'(i * 4), {16'h0, bs[i]}, RESP_OKAY);
    wr(OFS_ENABLES, 32'hFF, RESP_OKAY);
    pulse(8'hFF, 8'h00);
    irq_is(1'b1, 4'h1, 7'h0A);
    for (int s = 0; s < 8; s++) begin
      wr(ro[s], {16'h0, bs[ro[s][3:2]] | (16'h6 << sh[s])}, RESP_OKAY);
      repeat (2) @(posedge clk_i);
      irq_is(1'b1, 4'h7, USER_VEC_BASE + 7'(s));
      wr(ro[s], {16'h0, bs[ro[s][3:2]]}, RESP_OKAY);
    end
    wr(OFS_REQUEST_FLAGS, 32'hFF, RESP_OKAY);
  endtask : t_arb

  task automatic t_mask();
    wr(OFS_PRIORITY_SERIAL_ERROR, 32'h70, RESP_OKAY);
    wr(OFS_INTERRUPT_CONTROL, 32'h7, RESP_OKAY);
    pulse(8'h02, 8'h00);
    irq_is(1'b0, 4'h0, 7'h00);
    pulse(8'h00, 8'h80);
    irq_is(1'b1, 4'hF, 7'h07);
    wr(OFS_TRAP_FLAGS, 32'h80, RESP_OKAY);
    wr(OFS_INTERRUPT_CONTROL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk_i);
    irq_is(1'b1, 4'h7, 7'h0B);
    wr(OFS_REQUEST_FLAGS, 32'h2, RESP_OKAY);
  endtask : t_mask

  task automatic t_timed_irq_disable();
    wr(OFS_TIMED_DISABLE, 32'h28, RESP_OKAY);
    pulse(8'h01, 8'h00);
    irq_is(1'b0, 4'h0, 7'h00);
    pulse(8'h02, 8'h00);
    irq_is(1'b1, 4'h7, 7'h0B);
    wr(OFS_REQUEST_FLAGS, 32'h2, RESP_OKAY);
    repeat (40) @(posedge clk_i);
    irq_is(1'b1, 4'h1, 7'h0A);
    wr(OFS_REQUEST_FLAGS, 32'h1, RESP_OKAY);
  endtask : t_timed_irq_disable

  // Slow then prompt handler that never clears its flag: it must be re-entered
  task automatic t_cpu();
    for (int k = 0; k < 2; k++) begin
      svc <= (k == 0) ? 8'h06 : 8'h00;
      run <= 1'b1;
      acks = 0;
      pulse(8'h01, 8'h00);
      repeat (30) @(posedge clk_i);
      check("reentry", {31'h0, acks >= 2}, 32'h1);
      wr(OFS_REQUEST_FLAGS, 32'h1, RESP_OKAY);
      run <= 1'b0;
      repeat (20) @(posedge clk_i);
      check("cpu_level", {28'h0, cpu_level}, 32'h0);
    end
  endtask : t_cpu

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    final_report();
  end

  initial begin
    {awvalid, wvalid, arvalid, run} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, src_req, trap_req, svc} = 40'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    rst_b_i = 1'b0;
    mismatches = 0;
    compares = 0;
    acks = 0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_levels();
    t_arb();
    t_mask();
    t_timed_irq_disable();
    t_cpu();
    final_report();
  end
endmodule : ipas_top_test
